// file: rtl/pcn_pkg.sv
// Constants shared by the port C pad control and change-notification block.
// Overview of operation
// - Open-drain bit makes pin drive low only
// - Pull-up bit switches the weak pull-up on
// - Pull-up wins when both pulls requested
// - Pull-down active only with pull-up off
// - Control bit 15 enables change notification
// - Style bit one records edges in flags
// - Style bit zero compares against last read
// - Per-pin enable gates mismatch interrupts and rising-edge flags
// - Mismatch status shows change since read
// - Edge flag sets on enabled edge event
// - Second enable word enables falling edges
// - Pin driven from latch only when direction zero
package pcn_pkg;

   // ------------------------
   // Register indices; the byte address is four times the index.
   // ------------------------
   localparam int unsigned ADDR_W = 14;
   localparam logic [11:0] IDX_DIRECTION   = 12'hE3A;
   localparam logic [11:0] IDX_PORT_INPUT  = 12'hE3C;
   localparam logic [11:0] IDX_OUT_LATCH   = 12'hE3E;
   localparam logic [11:0] IDX_OPEN_DRAIN  = 12'hE40;
   localparam logic [11:0] IDX_PULLUP      = 12'hE42;
   localparam logic [11:0] IDX_PULLDOWN    = 12'hE44;
   localparam logic [11:0] IDX_CN_CONTROL  = 12'hE46;
   localparam logic [11:0] IDX_IRQ_ENABLE  = 12'hE48;
   localparam logic [11:0] IDX_MISMATCH    = 12'hE4A;
   localparam logic [11:0] IDX_EDGE_SELECT = 12'hE4C;
   localparam logic [11:0] IDX_EDGE_FLAGS  = 12'hE4E;
   localparam logic [11:0] IDX_EVT_STATUS  = 12'hE50;
   localparam logic [11:0] IDX_EVT_MASK    = 12'hE51;

   // ------------------------
   // Field positions and reset values.
   // ------------------------
   localparam int unsigned CN_ON_BIT     = 15;
   localparam int unsigned CN_STYLE_BIT  = 11;
   localparam logic [15:0] CN_CTRL_MASK  = 16'h8800;
   localparam int unsigned EVT_MISMATCH  = 0;
   localparam int unsigned EVT_EDGE      = 1;
   localparam logic [15:0] RST_WORD      = 16'h0000;
   localparam logic [15:0] RST_DIRECTION = 16'h0001;
   localparam logic [1:0]  RST_EVT_MASK  = 2'h3;
   localparam logic [1:0]  AXI_OKAY      = 2'h0;
   localparam logic [1:0]  AXI_SLVERR    = 2'h2;

endpackage : pcn_pkg

// file: rtl/pcn_reg_if.sv
// Register access carrier between the bus slave and the port logic.
`timescale 1ns/1ps
`default_nettype none
interface pcn_reg_if;
   import pcn_pkg::*;
   logic              wr_req;
   logic [ADDR_W-1:0] wr_addr;
   logic [31:0]       wr_data;
   logic [3:0]        wr_strb;
   logic              wr_hit;
   logic              rd_req;
   logic [ADDR_W-1:0] rd_addr;
   logic [31:0]       rd_data;
   logic              rd_hit;

   modport bus  (output wr_req, wr_addr, wr_data, wr_strb, rd_req, rd_addr,
                 input  wr_hit, rd_data, rd_hit);
   modport regs (input  wr_req, wr_addr, wr_data, wr_strb, rd_req, rd_addr,
                 output wr_hit, rd_data, rd_hit);
endinterface : pcn_reg_if
`default_nettype wire

// file: rtl/pcn_axil_slave.sv
// AXI4-Lite slave that turns bus transfers into single-cycle register requests.
`timescale 1ns/1ps
`default_nettype none
module pcn_axil_slave (
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   input  wire logic [pcn_pkg::ADDR_W-1:0] awaddr,
   input  wire logic                 awvalid,
   output logic                      awready,
   input  wire logic [31:0]          wdata,
   input  wire logic [3:0]           wstrb,
   input  wire logic                 wvalid,
   output logic                      wready,
   output logic [1:0]                bresp,
   output logic                      bvalid,
   input  wire logic                 bready,
   input  wire logic [pcn_pkg::ADDR_W-1:0] araddr,
   input  wire logic                 arvalid,
   output logic                      arready,
   output logic [31:0]               rdata,
   output logic [1:0]                rresp,
   output logic                      rvalid,
   input  wire logic                 rready,
   pcn_reg_if.bus                    rif
);
   import pcn_pkg::*;

   logic              aw_full_q;
   logic [ADDR_W-1:0] aw_addr_q;
   logic              w_full_q;
   logic [31:0]       w_data_q;
   logic [3:0]        w_strb_q;

   // ------------------------
   // Handshakes and request decode.
   // ------------------------
   // Address and data are parked separately so either may come first.
   assign awready     = !aw_full_q && !bvalid;
   assign wready      = !w_full_q && !bvalid;
   assign arready     = !rvalid;
   assign rif.wr_req  = aw_full_q && w_full_q;
   assign rif.wr_addr = aw_addr_q;
   assign rif.wr_data = w_data_q;
   assign rif.wr_strb = w_strb_q;
   assign rif.rd_req  = arvalid && arready;
   assign rif.rd_addr = araddr;

   // Write channel: capture, perform, then respond.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         aw_full_q <= 1'b0;
         aw_addr_q <= '0;
         w_full_q  <= 1'b0;
         w_data_q  <= 32'h0000_0000;
         w_strb_q  <= 4'h0;
         bvalid    <= 1'b0;
         bresp     <= AXI_OKAY;
      end else begin
         if (awvalid && awready) begin
            aw_full_q <= 1'b1;
            aw_addr_q <= awaddr;
         end
         if (wvalid && wready) begin
            w_full_q <= 1'b1;
            w_data_q <= wdata;
            w_strb_q <= wstrb;
         end
         if (rif.wr_req) begin
            aw_full_q <= 1'b0;
            w_full_q  <= 1'b0;
            bvalid    <= 1'b1;
            bresp     <= rif.wr_hit ? AXI_OKAY : AXI_SLVERR;
         end else if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   // Read channel: data is sampled at the address handshake.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rvalid <= 1'b0;
         rdata  <= 32'h0000_0000;
         rresp  <= AXI_OKAY;
      end else if (rif.rd_req) begin
         rvalid <= 1'b1;
         rdata  <= rif.rd_data;
         rresp  <= rif.rd_hit ? AXI_OKAY : AXI_SLVERR;
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
      end
   end
endmodule : pcn_axil_slave
`default_nettype wire

// file: rtl/pcn_port_c.sv
// Port C pad control and change-notification logic with its register file.
`timescale 1ns/1ps
`default_nettype none
module pcn_port_c #(
   parameter int unsigned PINS = 16
) (
   input  wire logic                       SYS_CLK,
   input  wire logic                       RST_N,
   input  wire logic [pcn_pkg::ADDR_W-1:0] S_AXI_AWADDR,
   input  wire logic                       S_AXI_AWVALID,
   output logic                            S_AXI_AWREADY,
   input  wire logic [31:0]                S_AXI_WDATA,
   input  wire logic [3:0]                 S_AXI_WSTRB,
   input  wire logic                       S_AXI_WVALID,
   output logic                            S_AXI_WREADY,
   output logic [1:0]                      S_AXI_BRESP,
   output logic                            S_AXI_BVALID,
   input  wire logic                       S_AXI_BREADY,
   input  wire logic [pcn_pkg::ADDR_W-1:0] S_AXI_ARADDR,
   input  wire logic                       S_AXI_ARVALID,
   output logic                            S_AXI_ARREADY,
   output logic [31:0]                     S_AXI_RDATA,
   output logic [1:0]                      S_AXI_RRESP,
   output logic                            S_AXI_RVALID,
   input  wire logic                       S_AXI_RREADY,
   input  wire logic [PINS-1:0]            PAD_IN,
   output logic [PINS-1:0]                 PAD_OUT,
   output logic [PINS-1:0]                 PAD_OE,
   output logic [PINS-1:0]                 PULLUP_ON,
   output logic [PINS-1:0]                 PULLDOWN_ON,
   output logic                            CN_IRQ
);
   import pcn_pkg::*;

   // ------------------------
   // Bus slave.
   // ------------------------
   pcn_reg_if rif ();

   pcn_axil_slave u_slave (
      .clk     (SYS_CLK),
      .rst_n   (RST_N),
      .awaddr  (S_AXI_AWADDR),
      .awvalid (S_AXI_AWVALID),
      .awready (S_AXI_AWREADY),
      .wdata   (S_AXI_WDATA),
      .wstrb   (S_AXI_WSTRB),
      .wvalid  (S_AXI_WVALID),
      .wready  (S_AXI_WREADY),
      .bresp   (S_AXI_BRESP),
      .bvalid  (S_AXI_BVALID),
      .bready  (S_AXI_BREADY),
      .araddr  (S_AXI_ARADDR),
      .arvalid (S_AXI_ARVALID),
      .arready (S_AXI_ARREADY),
      .rdata   (S_AXI_RDATA),
      .rresp   (S_AXI_RRESP),
      .rvalid  (S_AXI_RVALID),
      .rready  (S_AXI_RREADY),
      .rif     (rif.bus)
   );

   // ------------------------
   // Register state.
   // ------------------------
   logic [PINS-1:0] direction_q;
   logic [PINS-1:0] output_latch_q;
   logic [PINS-1:0] open_drain_q;
   logic [PINS-1:0] pullup_q;
   logic [PINS-1:0] pulldown_q;
   logic [15:0]     cn_control_q;
   logic [PINS-1:0] irq_enable_q;
   logic [PINS-1:0] mismatch_q;
   logic [PINS-1:0] mismatch_d;
   logic [PINS-1:0] edge_select_q;
   logic [PINS-1:0] edge_flags_q;
   logic [PINS-1:0] edge_flags_d;
   logic [PINS-1:0] last_read_q;
   logic [1:0]      evt_status_q;
   logic [1:0]      evt_status_d;
   logic [1:0]      evt_mask_q;

   // Pin synchroniser and the previous synchronised sample.
   logic [PINS-1:0] pin_meta_q;
   logic [PINS-1:0] pin_sync_q;
   logic [PINS-1:0] pin_prev_q;

   // ------------------------
   // Address decode.
   // ------------------------
   // Only word-aligned addresses select a register; others miss.
   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [11:0] idx);
      hit = (a == {idx, 2'b00});
   endfunction : hit

   // Byte-lane merge of a 16-bit register with the low half of a write.
   function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
      merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction : merge

   wire wa_direction  = hit(rif.wr_addr, IDX_DIRECTION);
   wire wa_latch      = hit(rif.wr_addr, IDX_OUT_LATCH);
   wire wa_open_drain = hit(rif.wr_addr, IDX_OPEN_DRAIN);
   wire wa_pullup     = hit(rif.wr_addr, IDX_PULLUP);
   wire wa_pulldown   = hit(rif.wr_addr, IDX_PULLDOWN);
   wire wa_control    = hit(rif.wr_addr, IDX_CN_CONTROL);
   wire wa_irq_enable = hit(rif.wr_addr, IDX_IRQ_ENABLE);
   wire wa_edge_sel   = hit(rif.wr_addr, IDX_EDGE_SELECT);
   wire wa_flags      = hit(rif.wr_addr, IDX_EDGE_FLAGS);
   wire wa_evt_status = hit(rif.wr_addr, IDX_EVT_STATUS);
   wire wa_evt_mask   = hit(rif.wr_addr, IDX_EVT_MASK);
   wire wa_port_input = hit(rif.wr_addr, IDX_PORT_INPUT);
   wire wa_mismatch   = hit(rif.wr_addr, IDX_MISMATCH);

   // Writes to the read-only words are accepted and ignored.
   assign rif.wr_hit = wa_direction | wa_latch | wa_open_drain | wa_pullup | wa_pulldown
                     | wa_control | wa_irq_enable | wa_edge_sel | wa_flags
                     | wa_evt_status | wa_evt_mask | wa_port_input | wa_mismatch;

   wire we_direction  = rif.wr_req && wa_direction;
   wire we_latch      = rif.wr_req && wa_latch;
   wire we_open_drain = rif.wr_req && wa_open_drain;
   wire we_pullup     = rif.wr_req && wa_pullup;
   wire we_pulldown   = rif.wr_req && wa_pulldown;
   wire we_control    = rif.wr_req && wa_control;
   wire we_irq_enable = rif.wr_req && wa_irq_enable;
   wire we_edge_sel   = rif.wr_req && wa_edge_sel;
   wire we_flags      = rif.wr_req && wa_flags;
   wire we_evt_status = rif.wr_req && wa_evt_status;
   wire we_evt_mask   = rif.wr_req && wa_evt_mask;

   // Read select; a read of the port input word also takes the snapshot.
   wire ra_port_input = hit(rif.rd_addr, IDX_PORT_INPUT);
   wire port_read     = rif.rd_req && ra_port_input;

   // ------------------------
   // Read data mux.
   // ------------------------
   logic [15:0] rd_word;
   logic        rd_match;
   always_comb begin
      rd_word  = 16'h0000;
      rd_match = 1'b1;
      if (hit(rif.rd_addr, IDX_DIRECTION))         rd_word = direction_q;
      else if (ra_port_input)                      rd_word = pin_sync_q;
      else if (hit(rif.rd_addr, IDX_OUT_LATCH))    rd_word = output_latch_q;
      else if (hit(rif.rd_addr, IDX_OPEN_DRAIN))   rd_word = open_drain_q;
      else if (hit(rif.rd_addr, IDX_PULLUP))       rd_word = pullup_q;
      else if (hit(rif.rd_addr, IDX_PULLDOWN))     rd_word = pulldown_q;
      else if (hit(rif.rd_addr, IDX_CN_CONTROL))   rd_word = cn_control_q;
      else if (hit(rif.rd_addr, IDX_IRQ_ENABLE))   rd_word = irq_enable_q;
      else if (hit(rif.rd_addr, IDX_MISMATCH))     rd_word = mismatch_q;
      else if (hit(rif.rd_addr, IDX_EDGE_SELECT))  rd_word = edge_select_q;
      else if (hit(rif.rd_addr, IDX_EDGE_FLAGS))   rd_word = edge_flags_q;
      else if (hit(rif.rd_addr, IDX_EVT_STATUS))   rd_word = {14'h0000, evt_status_q};
      else if (hit(rif.rd_addr, IDX_EVT_MASK))     rd_word = {14'h0000, evt_mask_q};
      else                                         rd_match = 1'b0;
   end
   assign rif.rd_data = {16'h0000, rd_word};
   assign rif.rd_hit  = rd_match;

   // ------------------------
   // Change-notification mode decode.
   // ------------------------
   wire cn_on       = cn_control_q[CN_ON_BIT];
   wire edge_style  = cn_control_q[CN_STYLE_BIT];
   wire mismatch_go = cn_on && !edge_style;
   wire edge_go     = cn_on && edge_style;

   // ------------------------
   // Per-pin pad drive, pulls and event detection.
   // ------------------------
   logic [PINS-1:0] new_edge;
   logic [PINS-1:0] flag_keep;

   // The flags word is written with zero to clear; a one leaves the bit.
   assign flag_keep = we_flags ? merge(edge_flags_q, rif.wr_data, rif.wr_strb)
                               : {PINS{1'b1}};

   genvar g;
   generate
      for (g = 0; g < PINS; g++) begin : g_pin
         // Open drain only ever pulls low; a high latch releases the pin.
         assign PAD_OUT[g] = open_drain_q[g] ? 1'b0 : output_latch_q[g];
         assign PAD_OE[g]  = !direction_q[g] &&
                             (!open_drain_q[g] || !output_latch_q[g]);
         assign PULLUP_ON[g]   = pullup_q[g];
         // The pull-up has priority so the two never fight on one pad.
         assign PULLDOWN_ON[g] = pulldown_q[g] && !pullup_q[g];

         // Rising edges use the first enable, falling edges the second.
         assign new_edge[g] = edge_go &&
                              ((irq_enable_q[g] && pin_sync_q[g] && !pin_prev_q[g]) ||
                               (edge_select_q[g] && !pin_sync_q[g] && pin_prev_q[g]));

         // An arriving edge beats a simultaneous software clear.
         assign edge_flags_d[g] = (edge_flags_q[g] && flag_keep[g]) || new_edge[g];

         // A port read restarts the comparison; the snapshot moves to the
         // value just read, so a later change is still caught.
         assign mismatch_d[g] = port_read ? 1'b0 :
                                (mismatch_q[g] ||
                                 (mismatch_go && (pin_sync_q[g] != last_read_q[g])));
      end
   endgenerate

   // ------------------------
   // Port interrupt.
   // ------------------------
   // Mismatch reaches the interrupt only on pins with the change enable.
   wire mismatch_pending = mismatch_go && |(mismatch_q & irq_enable_q);
   wire edge_pending     = edge_go && |edge_flags_q;

   // Sticky events: a fresh event wins over a write-one clear.
   always_comb begin
      evt_status_d = evt_status_q;
      if (we_evt_status) begin
         evt_status_d = evt_status_q & ~rif.wr_data[1:0];
      end
      evt_status_d[EVT_MISMATCH] = evt_status_d[EVT_MISMATCH] | mismatch_pending;
      evt_status_d[EVT_EDGE]     = evt_status_d[EVT_EDGE] | edge_pending;
   end

   // Level output; stays high while any unmasked status bit is set.
   assign CN_IRQ = |(evt_status_q & evt_mask_q);

   // ------------------------
   // Registers.
   // ------------------------
   // Two flip-flops on the pads, then one more for edge detection.
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         pin_meta_q <= '0;
         pin_sync_q <= '0;
         pin_prev_q <= '0;
      end else begin
         pin_meta_q <= PAD_IN;
         pin_sync_q <= pin_meta_q;
         pin_prev_q <= pin_sync_q;
      end
   end

   // Pad configuration words.
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         direction_q    <= RST_DIRECTION;
         output_latch_q <= RST_WORD;
         open_drain_q   <= RST_WORD;
         pullup_q       <= RST_WORD;
         pulldown_q     <= RST_WORD;
      end else begin
         if (we_direction)  direction_q    <= merge(direction_q, rif.wr_data, rif.wr_strb);
         if (we_latch)      output_latch_q <= merge(output_latch_q, rif.wr_data, rif.wr_strb);
         if (we_open_drain) open_drain_q   <= merge(open_drain_q, rif.wr_data, rif.wr_strb);
         if (we_pullup)     pullup_q       <= merge(pullup_q, rif.wr_data, rif.wr_strb);
         if (we_pulldown)   pulldown_q     <= merge(pulldown_q, rif.wr_data, rif.wr_strb);
      end
   end

   // Change-notification control and enables; unused control bits stay zero.
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         cn_control_q  <= RST_WORD;
         irq_enable_q  <= RST_WORD;
         edge_select_q <= RST_WORD;
      end else begin
         if (we_control)
            cn_control_q <= merge(cn_control_q, rif.wr_data, rif.wr_strb) & CN_CTRL_MASK;
         if (we_irq_enable) irq_enable_q  <= merge(irq_enable_q, rif.wr_data, rif.wr_strb);
         if (we_edge_sel)   edge_select_q <= merge(edge_select_q, rif.wr_data, rif.wr_strb);
      end
   end

   // Detection state: snapshot, mismatch status and edge flags.
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         last_read_q  <= RST_WORD;
         mismatch_q   <= RST_WORD;
         edge_flags_q <= RST_WORD;
      end else begin
         if (port_read) last_read_q <= pin_sync_q;
         mismatch_q   <= mismatch_d;
         edge_flags_q <= edge_flags_d;
      end
   end

   // Interrupt status and mask.
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         evt_status_q <= 2'h0;
         evt_mask_q   <= RST_EVT_MASK;
      end else begin
         evt_status_q <= evt_status_d;
         if (we_evt_mask) evt_mask_q <= rif.wr_data[1:0];
      end
   end
endmodule : pcn_port_c
`default_nettype wire

// file: tb/pcn_port_c_assertions.sv
// Port-level assertions for the port C pad and change-notification block.
`timescale 1ns/1ps
`default_nettype none
module pcn_port_c_assertions #(parameter int unsigned PINS = 16) (
   input wire logic [PINS-1:0] PAD_OUT,
   input wire logic [PINS-1:0] PAD_OE,
   input wire logic [PINS-1:0] PULLUP_ON,
   input wire logic [PINS-1:0] PULLDOWN_ON,
   input wire logic [13:0]     S_AXI_AWADDR,
   input wire logic [31:0]     S_AXI_WDATA,
   input wire logic [3:0]      S_AXI_WSTRB,
   input wire logic            SYS_CLK, RST_N, S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY,
   input wire logic            S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID
);
   import pcn_pkg::*;
   logic [13:0] aw_q;
   logic [15:0] wd_q, sh_q [6];
   logic [1:0]  ws_q, have_q;
   wire logic [13:0] off = aw_q - 14'h38E8;
   wire logic        hit = aw_q >= 14'h38E8 && aw_q <= 14'h3910 && aw_q[2:0] == 3'h0;
   wire logic [15:0] ln = {{8{ws_q[1]}}, {8{ws_q[0]}}};
   // Shadow of the pad words, committed with the slave's write.
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         aw_q <= '0;
         wd_q <= '0;
         ws_q <= '0;
         have_q <= '0;
         sh_q <= '{RST_DIRECTION, RST_WORD, RST_WORD, RST_WORD, RST_WORD, RST_WORD};
      end else begin
         if (S_AXI_AWVALID && S_AXI_AWREADY) aw_q <= S_AXI_AWADDR;
         if (S_AXI_WVALID && S_AXI_WREADY) wd_q <= S_AXI_WDATA[15:0];
         if (S_AXI_WVALID && S_AXI_WREADY) ws_q <= S_AXI_WSTRB[1:0];
         have_q <= &have_q ? 2'h0 : have_q | {S_AXI_AWVALID && S_AXI_AWREADY, S_AXI_WVALID && S_AXI_WREADY};
         if (&have_q && hit) sh_q[off[5:3]] <= (sh_q[off[5:3]] & ~ln) | (wd_q & ln);
      end
   end
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RST_N);
   pad_value_a: assert property (PAD_OUT == (sh_q[2] & ~sh_q[3])) else $error("pad value wrong");
   pad_enable_a: assert property (PAD_OE == (~sh_q[0] & ~(sh_q[3] & sh_q[2]))) else $error("pad enable wrong");
   pullup_on_a: assert property (PULLUP_ON == sh_q[4]) else $error("pull-up wrong");
   pulldown_on_a: assert property (PULLDOWN_ON == (sh_q[5] & ~sh_q[4])) else $error("pull-down wrong");
   write_answer_a: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
      |=> !S_AXI_BVALID ##1 S_AXI_BVALID) else $error("write answer mistimed");
   read_answer_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID) else $error("read answer late");
   bvalid_drop_a: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID) else $error("bvalid stuck");
   read_gate_a: assert property (S_AXI_ARREADY == !S_AXI_RVALID) else $error("arready wrong");
endmodule : pcn_port_c_assertions
bind pcn_port_c pcn_port_c_assertions #(.PINS(PINS)) u_chk (.PAD_OUT, .PAD_OE, .PULLUP_ON, .PULLDOWN_ON,
   .S_AXI_AWADDR, .S_AXI_WDATA, .S_AXI_WSTRB, .SYS_CLK, .RST_N, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WVALID,
   .S_AXI_WREADY, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RVALID);
`default_nettype wire

// file: tb/pcn_pins.sv
// Model of the outside of the port pins: drivers, weak pulls and floating lines.
`timescale 1ns/1ps
`default_nettype none
module pcn_pins (
   input  wire logic [15:0] pad_out,
   input  wire logic [15:0] pad_oe,
   input  wire logic [15:0] pull_up,
   input  wire logic [15:0] pull_dn,
   input  wire logic [15:0] ext_val,
   input  wire logic [15:0] ext_oe,
   output logic      [15:0] pad_in
);
   // Block, then outside driver, then pulls; a float shows the inverted outside value.
   assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_oe & ext_val)
                 | (~pad_oe & ~ext_oe & (pull_up | (~pull_dn & ~ext_val)));
endmodule : pcn_pins
`default_nettype wire

// file: tb/pcn_port_c_test.sv
// Self-checking bench for the port C pad and change-notification block.
`timescale 1ns/1ps
`default_nettype none
module pcn_port_c_test;
   import pcn_pkg::*;
   localparam logic [11:0] IX [13] = '{IDX_DIRECTION, IDX_PORT_INPUT, IDX_OUT_LATCH, IDX_OPEN_DRAIN, IDX_PULLUP,
      IDX_PULLDOWN, IDX_CN_CONTROL, IDX_IRQ_ENABLE, IDX_MISMATCH, IDX_EDGE_SELECT, IDX_EDGE_FLAGS, IDX_EVT_STATUS,
      IDX_EVT_MASK};
   localparam int DIR = 0, PORT = 1, LAT = 2, OD = 3, PU = 4, PD = 5, CTL = 6, IEN = 7, MIS = 8, ESEL = 9;
   localparam int FLG = 10, EVT = 11, MSK = 12;
   logic             clk = 1'b0, rst_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic             arvalid = 1'b0, rready = 1'b0;
   logic [13:0]      awaddr = '0, araddr = '0;
   logic [31:0]      wdata = '0;
   logic [3:0]       wstrb = '0;
   logic [15:0]      ext = '0, ext_oe = '0, v0, v1, r, f, d, m [13];
   wire logic        awready, wready, bvalid, arready, rvalid, irq;
   wire logic [1:0]  bresp, rresp;
   wire logic [31:0] rdata;
   wire logic [15:0] pin, pout, poe, pull_u, pull_d;
   int               fail_count = 0, n_compared = 0, seed = 32'h28526BFA;
   pcn_port_c #(.PINS(16)) u_dut (.SYS_CLK(clk), .RST_N(rst_n), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
      .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
      .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
      .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
      .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .PAD_IN(pin), .PAD_OUT(pout), .PAD_OE(poe),
      .PULLUP_ON(pull_u), .PULLDOWN_ON(pull_d), .CN_IRQ(irq));
   pcn_pins u_pins (.pad_out(pout), .pad_oe(poe), .pull_up(pull_u), .pull_dn(pull_d), .ext_val(ext),
      .ext_oe(ext_oe), .pad_in(pin));
   initial begin
      forever #2 clk = ~clk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // Index 13 is unmapped.
   task automatic wr(input int k, input logic [15:0] v, input logic [3:0] s);
      logic [15:0] ln;
      ln = {{8{s[1]}}, {8{s[0]}}};
      @(posedge clk);
      awaddr <= (k < 13) ? {IX[k], 2'h0} : 14'h0004;
      wdata <= {16'($random(seed)), v};
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
      check(bresp, (k < 13) ? AXI_OKAY : AXI_SLVERR);
      if (k == EVT) m[k] = m[k] & ~(v & ln);
      else if (k < 13 && k != PORT && k != MIS)
         m[k] = (m[k] & ~ln) | (v & ln & (k == CTL ? CN_CTRL_MASK : k == MSK ? 16'h0003 : 16'hFFFF));
   endtask : wr
   task automatic rd(input int k, input logic [15:0] e);
      @(posedge clk);
      araddr <= (k < 13) ? {IX[k], 2'h0} : 14'h0004;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge clk); while (!rvalid);
      rready <= 1'b0;
      check(rdata, {16'h0000, e});
      check(rresp, (k < 13) ? AXI_OKAY : AXI_SLVERR);
   endtask : rd
   task automatic end_sim;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : end_sim
   // Ends a hung run.
   initial begin
      #200000;
      fail_count++;
      end_sim();
   end
   initial begin
      for (int i = 0; i < 13; i++) m[i] = RST_WORD;
      m[DIR] = RST_DIRECTION;
      m[PORT] = 16'h0001; // Pin 0 floats high.
      m[MSK] = {14'h0000, RST_EVT_MASK};
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 14; i++) rd(i, (i < 13) ? m[i] : 16'h0000);
      // Random latch, open-drain and pull settings, read back through the pins.
      wr(DIR, 16'h0000, 4'h3);
      for (int n = 0; n < 6; n++) begin
         for (int k = LAT; k <= PD; k++) wr(k, 16'($random(seed)), 4'($random(seed)));
         wr(13, 16'hFFFF, 4'hF);
         rd(PORT, (m[LAT] & ~m[OD]) | (m[OD] & m[LAT] & (m[PU] | (~m[PD] & ~ext))));
      end
      wr(DIR, 16'hFFFF, 4'h3);
      rd(PORT, m[PU] | (~m[PD] & ~ext));
      // Edge style with the outside driving every pin.
      v0 = 16'($random(seed)) & 16'hFFFE;
      v1 = 16'($random(seed)) | 16'h0001;
      r = 16'($random(seed)) | 16'h0001;
      f = 16'($random(seed)) | 16'h0001;
      ext_oe <= 16'hFFFF;
      ext <= v0;
      wr(IEN, r, 4'h3);
      wr(ESEL, f, 4'h3);
      wr(CTL, 16'h8800, 4'h3);
      ext <= v1;
      repeat (5) @(posedge clk);
      m[FLG] = (~v0 & v1 & r) | (v0 & ~v1 & f);
      m[EVT] = 16'h0002;
      rd(FLG, m[FLG]);
      rd(EVT, m[EVT]);
      check(irq, 1'b1);
      wr(FLG, 16'h0000, 4'h3);
      wr(EVT, 16'h0002, 4'h1);
      rd(FLG, m[FLG]);
      check(irq, 1'b0);
      wr(MSK, 16'h0000, 4'h1);
      ext <= ~v1;
      repeat (5) @(posedge clk);
      m[FLG] = (v1 & f) | (~v1 & r);
      m[EVT] = 16'h0002;
      rd(FLG, m[FLG]);
      check(irq, 1'b0);
      wr(MSK, 16'h0003, 4'h1);
      check(irq, 1'b1);
      // Mismatch style against the value snapshotted by the last port read.
      wr(IEN, 16'h0000, 4'h3);
      wr(CTL, 16'h8000, 4'h3);
      wr(FLG, 16'h0000, 4'h3);
      rd(PORT, ~v1);
      wr(EVT, 16'h0003, 4'h1);
      d = 16'($random(seed)) | 16'h0001;
      ext <= ~v1 ^ d;
      repeat (5) @(posedge clk);
      rd(MIS, d);
      rd(EVT, m[EVT]);
      check(irq, 1'b0);
      wr(IEN, 16'hFFFF, 4'h3);
      m[EVT] = 16'h0001;
      rd(EVT, m[EVT]);
      check(irq, 1'b1);
      rd(PORT, ~v1 ^ d);
      rd(MIS, 16'h0000);
      // Port switched off: pin changes must leave every notification quiet.
      wr(EVT, 16'h0003, 4'h1);
      wr(CTL, 16'h0000, 4'h3);
      ext <= v1 ^ d;
      repeat (5) @(posedge clk);
      rd(MIS, 16'h0000);
      rd(FLG, 16'h0000);
      rd(EVT, m[EVT]);
      check(irq, 1'b0);
      end_sim();
   end
endmodule : pcn_port_c_test
`default_nettype wire
